// [common/rsd_cfg.svh]
// Constants for the reset, strap and pin-default sequencer
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

`define RSD_PIO_W         32
// Pins that keep their normal function after power-on reset (4 to 9)
`define RSD_NORMAL_MASK   32'h000003F0
// Pins whose power-on default is input with pulldown (1, 10, 22, 23)
`define RSD_PD_DEFAULT    32'h00C00402
// Synchronous-ready pin, the one normal pin with a pulldown choice
`define RSD_SYNC_READY_MASK     32'h00000040
// Pins whose pull choice is a pulldown
`define RSD_PD_MASK       (`RSD_PD_DEFAULT | `RSD_SYNC_READY_MASK)
// Clock-select pins 26 and 29, returned to bus use by a low strap
`define RSD_CLKSEL_MASK   32'h24000000
// Power-on defaults of the pin configuration
`define RSD_MODE_RST      (~`RSD_NORMAL_MASK)
`define RSD_DIR_RST       32'hFFFFFFFF
`define RSD_PULL_RST      32'hFFFFFFFF
`define RSD_PU_RST        (`RSD_MODE_RST & ~`RSD_PD_MASK)
`define RSD_PD_RST        (`RSD_MODE_RST & `RSD_PD_MASK)
// Reset vector where execution restarts
`define RSD_RESET_VECTOR  20'hFFFF0
// Strap reads high when not sampled yet (internal pullup)
`define RSD_STRAP_RST     1'h1
// Fetch delay after reset release, in half output-clock periods
`define RSD_FETCH_HALF    13
// Synchroniser depth on the reset input
`define RSD_SYNC_STAGES   2
// Cycles counted after the synchronised release, rounded up
`define RSD_FETCH_CYC     (((`RSD_FETCH_HALF + 1) / 2) - `RSD_SYNC_STAGES)
`define RSD_CNT_W         4

`endif

// [common/rsd_pkg.sv]
// Types shared by the reset, strap and pin-default sequencer
package rsd_pkg;

   // Bus phase sequencer states
   typedef enum logic [1:0] {
      RSD_IDLE = 2'b00,
      RSD_ADDR = 2'b01,
      RSD_TURN = 2'b10,
      RSD_DATA = 2'b11
   } rsd_bus_st_t;

endpackage

// [core/rsd_reset_sync.sv]
// Reset synchroniser: asynchronous assertion, clocked release
`timescale 1ns/10ps
module rsd_reset_sync #(
   parameter int STAGES = 2
) (
   input  wire logic mclk_i,      // Output clock
   input  wire logic reset_n_i,   // Raw reset pin, active low
   output logic      rst_n_o      // Synchronised reset, active low
);

   // Shift chain; only the last stage is read outside
   logic [STAGES-1:0] chain_q;

   // A single stage gives no settling time, so refuse it at elaboration
   if (STAGES < 2) begin
      $error("rsd_reset_sync needs at least two stages");
   end

   // Assert at once, release after STAGES edges to avoid metastability
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chain_q <= '0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], 1'b1};
      end
   end

   assign rst_n_o = chain_q[STAGES-1];

endmodule

// [core/rsd_top.sv]
// Reset entry and exit, strap capture, pin defaults and strobe control
`timescale 1ns/10ps
`include "rsd_cfg.svh"

// Summary of operation
// - Power-on pin defaults: pulldown, normal, pullup
// - Normal-default pins except synchronous-ready offer only pullup as PROGRAMMABLE_IO
// - Synchronous-ready pin as PROGRAMMABLE_IO offers pulldown
// - Low strap returns clock-select pins to bus
// - Read strobe waits until muxed bus released
// - Read strobe floats in hold and emulation
// - Reset abandons work, restarts at FFFF0h
// - Reset input synchronised before use
// - First fetch about 6.5 clocks after release
// - Byte-wide variant marks refresh cycles low
// - Refresh pin pulled up in reset, floats
// - High strap: disable-address bit gates bus
// - Disable-address set: address on dedicated pins
// - Low strap: bus always multiplexed, status pins
// - Strap sampled within three clocks of release
module rsd_top #(
   parameter bit BYTE_WIDE = 1'b1,                 // Byte-wide variant
   parameter int PIO_W     = `RSD_PIO_W            // Programmable pin count
) (
   input  wire logic             mclk_i,           // Output clock, 25 MHz
   input  wire logic             reset_n_i,        // Reset pin, async low
   input  wire logic             addr_enable_strap_i, // Strap pin level
   input  wire logic             pio_wr_i,         // Pin config write strobe
   input  wire logic [PIO_W-1:0] pio_mode_wr_i,    // 1 = general I/O
   input  wire logic [PIO_W-1:0] pio_dir_wr_i,     // 1 = input
   input  wire logic [PIO_W-1:0] pio_pull_wr_i,    // 1 = weak pull on
   input  wire logic             bus_hold_i,       // Bus hold granted
   input  wire logic             on_circuit_emulation_mode_mode_i,      // Emulation mode active
   input  wire logic             cyc_start_i,      // Bus cycle starts
   input  wire logic             cyc_read_i,       // Cycle is a read
   input  wire logic             cyc_end_i,        // Data phase done
   input  wire logic             upper_chip_select_i, // Upper region hit
   input  wire logic             lower_chip_select_i, // Lower region hit
   input  wire logic             upper_da_i,       // Upper region address off
   input  wire logic             lower_da_i,       // Lower region address off
   input  wire logic             refresh_cycle_i,  // Refresh cycle running
   input  wire logic             psram_mode_i,     // PSRAM mode selected
   output logic [PIO_W-1:0]      pio_mode_o,       // Pin is general I/O
   output logic [PIO_W-1:0]      pio_in_o,         // Pin is an input
   output logic [PIO_W-1:0]      pio_pu_o,         // Pullup active
   output logic [PIO_W-1:0]      pio_pd_o,         // Pulldown active
   output logic                  strap_high_o,     // Captured strap level
   output logic                  status6_en_o,     // Status bit 6 normal
   output logic                  zero_instr_en_o,  // Zero-instr pin normal
   output logic                  ad_addr_oe_o,     // Muxed bus drives address
   output logic                  addr_pins_oe_o,   // Dedicated address pins
   output logic                  rd_n_o,           // Read strobe, active low
   output logic                  rd_oe_o,          // Read strobe driven
   output logic                  refresh_indicate_n_o, // Refresh mark
   output logic                  refresh_oe_o,     // Refresh pin driven
   output logic                  refresh_pu_o,     // Refresh pin pullup on
   output logic                  midsel3_refresh_n_o, // PSRAM refresh mark
   output logic                  fetch_start_o,    // First fetch pulse
   output logic [19:0]           fetch_addr_o      // First fetch address
);

   // Pin masks are fixed words, so any other width is refused at elaboration
   if (PIO_W != `RSD_PIO_W) begin
      $error("rsd_top pin masks are built for 32 pins");
   end

   // Synchronised reset; every state flop below except the strap synchroniser clears on it
   logic                rst_n;              // Internal reset, active low
   // Strap pin synchroniser
   logic                strap_s1_q;         // First stage
   logic                strap_s2_q;         // Second stage
   logic                sampled_q;          // Strap already captured
   logic                strap_q;            // Captured strap level
   // Pin configuration store
   logic [PIO_W-1:0]    mode_q;             // General I/O select
   logic [PIO_W-1:0]    dir_q;              // Direction, 1 = input
   logic [PIO_W-1:0]    pull_q;             // Pull enable
   // Fetch delay
   logic [`RSD_CNT_W-1:0] fetch_cnt_q;      // Cycles since release
   logic                fetch_done_q;       // First fetch issued
   // Bus phase sequencer
   rsd_pkg::rsd_bus_st_t st_q;              // Current phase
   rsd_pkg::rsd_bus_st_t st_d;              // Next phase
   logic                read_q;             // Cycle in flight is a read
   logic                floating;           // Hold or emulation
   logic                addr_suppress;      // Address off the muxed bus

   // Weak pull selection for one pull direction
   function automatic logic [PIO_W-1:0] pull_sel(
      input logic [PIO_W-1:0] mode,
      input logic [PIO_W-1:0] dir,
      input logic [PIO_W-1:0] pull,
      input logic [PIO_W-1:0] kind
   );
      pull_sel = mode & dir & pull & kind;
   endfunction

   // Reset release is synchronised before anything acts on it
   rsd_reset_sync #(
      .STAGES (`RSD_SYNC_STAGES)
   ) u_rst_sync (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .rst_n_o   (rst_n)
   );

   // Strap pin passes two flops; no reset so the pin is seen at release
   always_ff @(posedge mclk_i) begin
      strap_s1_q <= addr_enable_strap_i;
      strap_s2_q <= strap_s1_q;
   end

   // Capture the strap once, first edge after internal release
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sampled_q <= 1'b0;
         strap_q   <= `RSD_STRAP_RST;
      end else if (!sampled_q) begin
         sampled_q <= 1'b1;
         strap_q   <= strap_s2_q;
      end
      // Once captured the level stays until the next reset
   end

   // Strap-driven pin functions, held in flops
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_high_o    <= `RSD_STRAP_RST;
         status6_en_o    <= 1'b0;
         zero_instr_en_o <= 1'b0;
      end else begin
         strap_high_o    <= strap_q;
         status6_en_o    <= sampled_q & ~strap_q;
         zero_instr_en_o <= sampled_q & ~strap_q;
      end
   end

   // Pin configuration: power-on defaults, strap revert, writes
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `RSD_MODE_RST;
         dir_q  <= `RSD_DIR_RST;
         pull_q <= `RSD_PULL_RST;
      end else if (!sampled_q && !strap_s2_q) begin
         // Low strap gives the clock-select pins back to the bus
         mode_q <= mode_q & ~`RSD_CLKSEL_MASK;
      end else if (pio_wr_i) begin
         mode_q <= pio_mode_wr_i;
         dir_q  <= pio_dir_wr_i;
         pull_q <= pio_pull_wr_i;
      end
   end

   // Pin outputs; pull kind is fixed per pin, so normal-default pins
   // only ever get a pullup except the synchronous-ready pin
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pio_mode_o <= `RSD_MODE_RST;
         pio_in_o   <= `RSD_DIR_RST;
         pio_pu_o   <= `RSD_PU_RST;
         pio_pd_o   <= `RSD_PD_RST;
      end else begin
         pio_mode_o <= mode_q;
         pio_in_o   <= dir_q;
         pio_pu_o   <= pull_sel(mode_q, dir_q, pull_q, ~`RSD_PD_MASK);
         pio_pd_o   <= pull_sel(mode_q, dir_q, pull_q, `RSD_PD_MASK);
      end
   end

   // First fetch after the documented delay; reset abandons it
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         fetch_cnt_q   <= '0;
         fetch_done_q  <= 1'b0;
         fetch_start_o <= 1'b0;
      end else begin
         fetch_start_o <= 1'b0;
         if (!fetch_done_q) begin
            if (fetch_cnt_q == `RSD_CNT_W'(`RSD_FETCH_CYC - 1)) begin
               fetch_done_q  <= 1'b1;
               fetch_start_o <= 1'b1;
            end else begin
               fetch_cnt_q <= fetch_cnt_q + `RSD_CNT_W'(1);
            end
         end
      end
   end

   // Restart address is fixed; held as a flop like every output
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         fetch_addr_o <= `RSD_RESET_VECTOR;
      end else begin
         fetch_addr_o <= `RSD_RESET_VECTOR;
      end
   end

   assign floating = bus_hold_i | on_circuit_emulation_mode_mode_i;
   // With a high strap each region's disable-address bit gates the bus
   assign addr_suppress = strap_q &
      ((upper_chip_select_i & upper_da_i) |
       (lower_chip_select_i & lower_da_i));

   // Phase sequencing; the turn phase keeps the strobe off the bus
   // until the address drivers have let go
   always_comb begin
      st_d = st_q;
      case (st_q)
         rsd_pkg::RSD_IDLE: begin
            if (cyc_start_i) begin
               st_d = rsd_pkg::RSD_ADDR;
            end
         end
         rsd_pkg::RSD_ADDR: begin
            st_d = rsd_pkg::RSD_TURN;
         end
         rsd_pkg::RSD_TURN: begin
            st_d = rsd_pkg::RSD_DATA;
         end
         rsd_pkg::RSD_DATA: begin
            if (cyc_end_i) begin
               st_d = rsd_pkg::RSD_IDLE;
            end
         end
         default: begin
            st_d = rsd_pkg::RSD_IDLE;
         end
      endcase
      // Hold or emulation abandons the cycle
      if (floating) begin
         st_d = rsd_pkg::RSD_IDLE;
      end
   end

   // Phase register and read flag
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= rsd_pkg::RSD_IDLE;
         read_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (st_q == rsd_pkg::RSD_IDLE && cyc_start_i) begin
            read_q <= cyc_read_i;
         end
      end
   end

   // Bus drivers follow the next phase so outputs stay flop-driven
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ad_addr_oe_o   <= 1'b0;
         addr_pins_oe_o <= 1'b0;
         rd_n_o         <= 1'b1;
         rd_oe_o        <= 1'b0;
      end else begin
         ad_addr_oe_o   <= (st_d == rsd_pkg::RSD_ADDR) & ~addr_suppress;
         addr_pins_oe_o <= ~floating;
         // Strobe only in the data phase, a full phase after release
         rd_n_o  <= ~((st_d == rsd_pkg::RSD_DATA) &
                      ((st_q == rsd_pkg::RSD_IDLE) ? cyc_read_i : read_q));
         rd_oe_o <= ~floating;
      end
   end

   // Refresh indication; PSRAM refresh moves to the chip-select pin
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         refresh_indicate_n_o <= 1'b1;
         refresh_oe_o         <= 1'b0;
         refresh_pu_o         <= 1'b1;
         midsel3_refresh_n_o  <= 1'b1;
      end else begin
         refresh_indicate_n_o <= ~(BYTE_WIDE & refresh_cycle_i &
                                   ~psram_mode_i);
         refresh_oe_o         <= BYTE_WIDE & ~floating;
         refresh_pu_o         <= 1'b0;
         midsel3_refresh_n_o  <= ~(psram_mode_i & refresh_cycle_i);
      end
   end

endmodule

// [bench/rsd_top_sva.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
module rsd_top_sva #(
   parameter int PIO_W = 32
) (
   input wire logic             mclk_i,
   input wire logic             reset_n_i,
   input wire logic             cyc_start_i,
   input wire logic             cyc_read_i,
   input wire logic             bus_hold_i,
   input wire logic             on_circuit_emulation_mode_mode_i,
   input wire logic             upper_chip_select_i,
   input wire logic             upper_da_i,
   input wire logic             refresh_cycle_i,
   input wire logic             psram_mode_i,
   input wire logic [PIO_W-1:0] pio_mode_o,
   input wire logic             strap_high_o,
   input wire logic             status6_en_o,
   input wire logic             zero_instr_en_o,
   input wire logic             ad_addr_oe_o,
   input wire logic             addr_pins_oe_o,
   input wire logic             rd_n_o,
   input wire logic             rd_oe_o,
   input wire logic             refresh_indicate_n_o,
   input wire logic             refresh_oe_o,
   input wire logic             midsel3_refresh_n_o,
   input wire logic             fetch_start_o,
   input wire logic [19:0]      fetch_addr_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   logic [3:0] rc_q;                      // Edges since pin release, saturating
   wire        hb = bus_hold_i | on_circuit_emulation_mode_mode_i; // Bus given away
   // Count from the pin release so timing is tied to the pin
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rc_q <= 4'h0;
      else if (rc_q != 4'hF)
         rc_q <= rc_q + 4'h1;
   end
   a_rd_after_float: assert property ($fell(rd_n_o) |-> !ad_addr_oe_o && !$past(ad_addr_oe_o))
      else $error("read strobe fell while bus drove address");
   a_rd_turn_delay: assert property (($rose(ad_addr_oe_o) && $past(cyc_read_i) && !hb ##1 !hb)
      |=> !rd_n_o) else $error("read strobe late after turn");
   a_rd_float_hold: assert property (hb |=> !rd_oe_o)
      else $error("read strobe driven in hold");
   a_rfsh_float_hold: assert property (hb |=> !refresh_oe_o)
      else $error("refresh pin driven in hold");
   a_addr_suppress: assert property ((rc_q > 4'h4 && cyc_start_i && strap_high_o && !hb &&
      upper_chip_select_i && upper_da_i) |=> !ad_addr_oe_o && addr_pins_oe_o)
      else $error("address not suppressed");
   a_strap_held: assert property (rc_q > 4'h4 |-> $stable(strap_high_o))
      else $error("strap capture moved");
   a_status_pins: assert property (rc_q > 4'h4 |-> status6_en_o == !strap_high_o &&
      zero_instr_en_o == !strap_high_o) else $error("status pin mode wrong");
   a_fetch_time: assert property (fetch_start_o == (rc_q == 4'h7))
      else $error("first fetch at wrong edge");
   a_fetch_vector: assert property (fetch_start_o |-> fetch_addr_o == 20'hFFFF0)
      else $error("fetch address wrong");
   a_refresh_mark: assert property ((rc_q > 4'h4 && refresh_cycle_i && !psram_mode_i && !hb)
      |=> !refresh_indicate_n_o && midsel3_refresh_n_o) else $error("refresh mark");
   a_psram_mark: assert property ((rc_q > 4'h4 && refresh_cycle_i && psram_mode_i && !hb)
      |=> refresh_indicate_n_o && !midsel3_refresh_n_o) else $error("psram mark");
   a_clksel_revert: assert property ((rc_q == 4'h4 && !strap_high_o) |->
      !pio_mode_o[26] && !pio_mode_o[29]) else $error("clock-select pins kept");
endmodule

bind rsd_top rsd_top_sva #(.PIO_W(PIO_W)) i_rsd_top_sva (.*);

// [bench/rsd_ext_model.sv]
// Far side: reset source and a read-answering memory
`timescale 1ns/10ps
module rsd_ext_model #(
   parameter int RST_CYC = 16            // Reset length, cut from 1 ms for run time
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_req_i,    // Start a new reset pulse
   input  wire logic [3:0] wait_i,       // Memory wait states
   input  wire logic       rd_n_i,       // Read strobe from the block
   output logic            reset_n_o,    // Reset pin to the block
   output logic            cyc_end_o     // Data phase finished
);
   int         rcnt_q = 0;               // Reset edges counted
   logic [3:0] wcnt_q = 4'h0;            // Wait states counted
   initial reset_n_o = 1'b0;
   initial cyc_end_o = 1'b0;
   // Reset held low with the clock running all the while
   always @(posedge mclk_i) begin
      if (rst_req_i) begin
         rcnt_q <= 0;
         reset_n_o <= 1'b0;
      end else if (rcnt_q < RST_CYC) begin
         rcnt_q <= rcnt_q + 1;
      end else begin
         reset_n_o <= 1'b1;
      end
   end
   // Ends a read after the wait states, one pulse only
   always @(posedge mclk_i) begin
      if (cyc_end_o || rd_n_i) begin
         cyc_end_o <= 1'b0;
         wcnt_q <= 4'h0;
      end else if (wcnt_q == wait_i)
         cyc_end_o <= 1'b1;
      else
         wcnt_q <= wcnt_q + 4'h1;
   end
endmodule

// [bench/rsd_top_tb_top.sv]
// Self-checking bench for the reset, strap and pin-default sequencer
`timescale 1ns/10ps
module rsd_top_tb_top;
   logic        mclk_i = 1'b0, reset_n_i, cyc_end_i, rst_req = 1'b0;
   logic        addr_enable_strap_i = 1'b1, pio_wr_i = 1'b0, cyc_read_i = 1'b1;
   logic [31:0] pio_mode_wr_i = 32'h0, pio_dir_wr_i = 32'h0, pio_pull_wr_i = 32'h0;
   logic        bus_hold_i = 1'b0, on_circuit_emulation_mode_mode_i = 1'b0, cyc_start_i = 1'b0;
   logic        upper_chip_select_i = 1'b0, lower_chip_select_i = 1'b0;
   logic        upper_da_i = 1'b0, lower_da_i = 1'b0, refresh_cycle_i = 1'b0;
   logic        psram_mode_i = 1'b0;
   logic [3:0]  wt = 4'h0;
   logic [31:0] pio_mode_o, pio_in_o, pio_pu_o, pio_pd_o;
   logic [19:0] fetch_addr_o;
   logic        strap_high_o, status6_en_o, zero_instr_en_o, ad_addr_oe_o, addr_pins_oe_o;
   logic        rd_n_o, rd_oe_o, refresh_indicate_n_o, refresh_oe_o, refresh_pu_o;
   logic        midsel3_refresh_n_o, fetch_start_o;
   int          errors = 0, checked = 0, n;
   // Config words beside the pulls they must give
   typedef struct { logic [31:0] m, d, p, pu, pd; } rsd_row_t;
   rsd_row_t rows [3] = '{
      '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF3FFBBD, 32'h00C00442},
      '{32'h000003F0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000003B0, 32'h00000040},
      '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0000FBBD, 32'h00000442}};
   always #20 mclk_i = ~mclk_i;
   rsd_ext_model i_rsd_ext_model (.mclk_i(mclk_i), .rst_req_i(rst_req), .wait_i(wt),
      .rd_n_i(rd_n_o), .reset_n_o(reset_n_i), .cyc_end_o(cyc_end_i));
   rsd_top i_rsd_top (.*);
   task automatic tick();
      @(posedge mclk_i);
      #1;
   endtask
   task automatic chk_bit(string s, logic e, logic g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_word(string s, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Reset with a strap level; the strap flips after capture
   task automatic do_reset(logic s);
      addr_enable_strap_i = s;
      rst_req = 1'b1;
      tick();
      rst_req = 1'b0;
      tick();
      chk_word("mode_rst", 32'hFFFFFC0F, pio_mode_o);
      chk_word("pu_rst", 32'hFF3FF80D, pio_pu_o);
      chk_word("pd_rst", 32'h00C00402, pio_pd_o);
      chk_word("in_rst", 32'hFFFFFFFF, pio_in_o);
      chk_bit("rfsh_pu_rst", 1'b1, refresh_pu_o);
      chk_bit("rd_oe_rst", 1'b0, rd_oe_o);
      n = 0;
      while (reset_n_i !== 1'b1 && n < 40) begin
         tick();
         n++;
      end
      n = 0;
      while (fetch_start_o !== 1'b1 && n < 12) begin
         tick();
         n++;
         if (n == 3)
            addr_enable_strap_i = !s;
      end
      chk_word("fetch_edges", 32'h7, 32'(n));
      chk_word("fetch_addr", 32'h000FFFF0, {12'h000, fetch_addr_o});
      chk_bit("strap", s, strap_high_o);
      $display("Test reset with strap %0d done", s);
   endtask
   // One read cycle through the memory model
   task automatic bus(logic u, logic l, logic da, logic e);
      upper_chip_select_i = u;
      lower_chip_select_i = l;
      upper_da_i = da;
      lower_da_i = da;
      cyc_start_i = 1'b1;
      tick();
      cyc_start_i = 1'b0;
      chk_bit("ad_addr_oe", e, ad_addr_oe_o);
      chk_bit("addr_pins_oe", 1'b1, addr_pins_oe_o);
      tick();
      chk_bit("rd_n_turn", 1'b1, rd_n_o);
      tick();
      chk_bit("rd_n_data", 1'b0, rd_n_o);
      n = 0;
      while (rd_n_o !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      chk_bit("rd_n_end", 1'b1, rd_n_o);
      tick();
   endtask
   initial begin
      do_reset(1'b1);
      chk_word("mode_hi", 32'hFFFFFC0F, pio_mode_o);
      chk_bit("status6_hi", 1'b0, status6_en_o);
      foreach (rows[i]) begin
         pio_mode_wr_i = rows[i].m;
         pio_dir_wr_i = rows[i].d;
         pio_pull_wr_i = rows[i].p;
         pio_wr_i = 1'b1;
         tick();
         pio_wr_i = 1'b0;
         tick();
         tick();
         chk_word("mode", rows[i].m, pio_mode_o);
         chk_word("in", rows[i].d, pio_in_o);
         chk_word("pu", rows[i].pu, pio_pu_o);
         chk_word("pd", rows[i].pd, pio_pd_o);
      end
      $display("Test pin table done");
      bus(1'b1, 1'b0, 1'b1, 1'b0);
      bus(1'b1, 1'b0, 1'b0, 1'b1);
      bus(1'b0, 1'b1, 1'b1, 1'b0);
      bus(1'b0, 1'b0, 1'b1, 1'b1);
      $display("Test address suppress done");
      // Hold cuts a read short, then emulation a write; slow memory meanwhile
      wt = 4'h9;
      for (int k = 0; k < 2; k++) begin
         // Read cut by hold, then a write cut by emulation
         cyc_read_i = (k == 0);
         cyc_start_i = 1'b1;
         tick();
         cyc_start_i = 1'b0;
         repeat (2) tick();
         chk_bit("rd_n_kind", k[0], rd_n_o);
         bus_hold_i = (k == 0);
         on_circuit_emulation_mode_mode_i = (k == 1);
         repeat (2) tick();
         chk_bit("rd_oe_hold", 1'b0, rd_oe_o);
         chk_bit("rfsh_oe_hold", 1'b0, refresh_oe_o);
         bus_hold_i = 1'b0;
         on_circuit_emulation_mode_mode_i = 1'b0;
         repeat (12) tick();
         chk_bit("rd_oe_free", 1'b1, rd_oe_o);
         chk_bit("rfsh_oe_free", 1'b1, refresh_oe_o);
      end
      cyc_read_i = 1'b1;
      bus(1'b0, 1'b0, 1'b0, 1'b1);
      $display("Test hold abort done");
      for (int k = 0; k < 2; k++) begin
         psram_mode_i = k[0];
         refresh_cycle_i = 1'b1;
         repeat (2) tick();
         chk_bit("rfsh_mark", k[0], refresh_indicate_n_o);
         chk_bit("midsel3_mark", !k[0], midsel3_refresh_n_o);
         refresh_cycle_i = 1'b0;
         tick();
      end
      psram_mode_i = 1'b0;
      $display("Test refresh done");
      do_reset(1'b0);
      chk_word("mode_lo", 32'hDBFFFC0F, pio_mode_o);
      chk_word("pu_lo", 32'hDB3FF80D, pio_pu_o);
      chk_bit("status6_lo", 1'b1, status6_en_o);
      chk_bit("zero_instr_lo", 1'b1, zero_instr_en_o);
      bus(1'b1, 1'b0, 1'b1, 1'b1);
      $display("Test strap low done");
      final_report();
   end
   // About 150 cycles of work; 10000 cycles means a hang
   initial begin
      #400000;
      errors++;
      final_report();
   end
endmodule
